/* core/icfg_config_bits.sv */
// Configuration bits 13..7 of the serial bus controller: clock stretch,
// slave transmit request interrupt, general call clear, master clock.
// Assumes open-drain pins resolved outside; SCL and SDA are asynchronous.
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps

// Behaviour
// - bit 11 holds SCL low
// - bit 9 set suppresses transmit request
// - request after R/W bit falling edge
// - bit 8 clears general call, self-clears
// - bit 7 enables master serial clock
// - any general call sets status
module icfg_config_bits #(
    parameter int ADDR_W = 4,
    parameter int MCLK_HALF = icfg_pkg::ICFG_MCLK_HALF_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [6:0] slave_addr,
    input wire logic master_active,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic scl_oe,
    output logic slave_tx_req,
    output logic irq
);

    // Refuse settings that the counters and decoder cannot serve
    initial begin
        if (ADDR_W < 4) begin
            $error("ADDR_W must be at least 4");
        end
        if (MCLK_HALF < 1 || MCLK_HALF > 255) begin
            $error("MCLK_HALF must lie in 1..255");
        end
        if (MCLK_HALF > (1 << icfg_pkg::ICFG_DIV_W)) begin
            $error("MCLK_HALF does not fit the divider");
        end
        if (ADDR_W > 32) begin
            $error("ADDR_W must not exceed 32");
        end
    end

    // Divider counts 0..HALF_LAST, so one SCL phase is MCLK_HALF cycles
    localparam logic [icfg_pkg::ICFG_DIV_W-1:0] HALF_LAST =
        icfg_pkg::ICFG_DIV_W'(MCLK_HALF - 1);

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [3:0] ofs);
        hit = (a == ADDR_W'(ofs));
    endfunction : hit

    // Pin synchronisers and edge history
    // Reset to the idle high level so that no false edge follows reset;
    // only the second stage is read, the first may be metastable
    logic scl_s1_reg, scl_s2_reg, scl_prev_reg;
    logic sda_s1_reg, sda_s2_reg, sda_prev_reg;
    logic scl_rise, scl_fall, start_seen, stop_seen;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            scl_s1_reg <= 1'b1;
            scl_s2_reg <= 1'b1;
            scl_prev_reg <= 1'b1;
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_s1_reg <= scl_in;
            scl_s2_reg <= scl_s1_reg;
            scl_prev_reg <= scl_s2_reg;
            sda_s1_reg <= sda_in;
            sda_s2_reg <= sda_s1_reg;
            sda_prev_reg <= sda_s2_reg;
        end
    end

    // START and STOP need SCL high on both samples, so a data change
    // while SCL is low never counts as either
    always_comb begin
        scl_rise = scl_s2_reg & ~scl_prev_reg;
        scl_fall = ~scl_s2_reg & scl_prev_reg;
        start_seen = scl_s2_reg & scl_prev_reg & sda_prev_reg & ~sda_s2_reg;
        stop_seen = scl_s2_reg & scl_prev_reg & ~sda_prev_reg & sda_s2_reg;
    end

    // Configuration register and register port
    icfg_pkg::icfg_cfg_s cfg_reg, cfg_next;
    logic [icfg_pkg::ICFG_IRQ_W-1:0] irq_st_reg, irq_st_next;
    logic [icfg_pkg::ICFG_IRQ_W-1:0] irq_mask_reg, irq_mask_next;
    logic gc_st_reg, gc_st_next;
    logic [31:0] rdata_reg, rdata_next;
    logic irq_reg, irq_next;
    logic tx_evt, gc_evt;
    logic [icfg_pkg::ICFG_IRQ_W-1:0] evt_vec, w1c_vec, gcclr_vec;

    always_comb begin
        cfg_next = cfg_reg;
        irq_mask_next = irq_mask_reg;
        w1c_vec = '0;
        gcclr_vec = '0;
        evt_vec = '0;
        evt_vec[icfg_pkg::ICFG_IRQ_TXREQ] = tx_evt;
        evt_vec[icfg_pkg::ICFG_IRQ_GCALL] = gc_evt;
        // The clear runs one cycle after the write, so a read right
        // after the write still shows bit 8 set
        // self-clearing command
        if (cfg_reg.gc_clear) begin
            cfg_next.gc_clear = 1'b0;
            gcclr_vec[icfg_pkg::ICFG_IRQ_GCALL] = 1'b1;
        end
        if (reg_wr) begin
            if (hit(reg_addr, icfg_pkg::ICFG_OFS_CONFIG)) begin
                // bits 13, 12, 10 are not stored
                cfg_next.stretch = reg_wdata[icfg_pkg::ICFG_BIT_STRETCH];
                cfg_next.txreq_off = reg_wdata[icfg_pkg::ICFG_BIT_TXREQ_OFF];
                cfg_next.mclk_en = reg_wdata[icfg_pkg::ICFG_BIT_MCLK_EN];
                if (reg_wdata[icfg_pkg::ICFG_BIT_GC_CLEAR]) begin
                    cfg_next.gc_clear = 1'b1;
                end
            end
            if (hit(reg_addr, icfg_pkg::ICFG_OFS_IRQ_STATUS)) begin
                w1c_vec = reg_wdata[icfg_pkg::ICFG_IRQ_W-1:0];
            end
            if (hit(reg_addr, icfg_pkg::ICFG_OFS_IRQ_MASK)) begin
                irq_mask_next = reg_wdata[icfg_pkg::ICFG_IRQ_W-1:0];
            end
        end
        // New events win over a clear in the same cycle
        irq_st_next = (irq_st_reg & ~w1c_vec & ~gcclr_vec) | evt_vec;
        gc_st_next = (gc_st_reg & ~cfg_reg.gc_clear) | gc_evt;
        irq_next = |(irq_st_next & irq_mask_next);
        // Read data stand one cycle and are zero otherwise, so a late
        // sample shows zero rather than stale data
        rdata_next = 32'h0000_0000;
        if (reg_rd) begin
            if (hit(reg_addr, icfg_pkg::ICFG_OFS_CONFIG)) begin
                rdata_next[icfg_pkg::ICFG_BIT_STRETCH] = cfg_reg.stretch;
                rdata_next[icfg_pkg::ICFG_BIT_TXREQ_OFF] = cfg_reg.txreq_off;
                rdata_next[icfg_pkg::ICFG_BIT_GC_CLEAR] = cfg_reg.gc_clear;
                rdata_next[icfg_pkg::ICFG_BIT_MCLK_EN] = cfg_reg.mclk_en;
            end
            if (hit(reg_addr, icfg_pkg::ICFG_OFS_IRQ_STATUS)) begin
                rdata_next[icfg_pkg::ICFG_IRQ_W-1:0] = irq_st_reg;
            end
            if (hit(reg_addr, icfg_pkg::ICFG_OFS_IRQ_MASK)) begin
                rdata_next[icfg_pkg::ICFG_IRQ_W-1:0] = irq_mask_reg;
            end
            if (hit(reg_addr, icfg_pkg::ICFG_OFS_GC_STATUS)) begin
                rdata_next[0] = gc_st_reg;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cfg_reg <= '0;
            irq_st_reg <= icfg_pkg::ICFG_RST_IRQ;
            irq_mask_reg <= icfg_pkg::ICFG_RST_IRQ;
            gc_st_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            irq_reg <= 1'b0;
        end else begin
            cfg_reg <= cfg_next;
            irq_st_reg <= irq_st_next;
            irq_mask_reg <= irq_mask_next;
            gc_st_reg <= gc_st_next;
            rdata_reg <= rdata_next;
            irq_reg <= irq_next;
        end
    end

    // Link watcher: address byte of each frame
    // The first fall after START opens bit 7; the ninth ends the R/W bit,
    // which is where the transmit request fires. Data bytes are not
    // looked at, so the watcher idles until the next START or STOP.
    icfg_pkg::icfg_link_e link_reg, link_next;
    logic [7:0] shift_reg, shift_next;
    logic [3:0] bits_reg, bits_next;
    logic txpulse_reg, txpulse_next;

    always_comb begin
        link_next = link_reg;
        shift_next = shift_reg;
        bits_next = bits_reg;
        tx_evt = 1'b0;
        gc_evt = 1'b0;
        if (start_seen) begin
            link_next = icfg_pkg::ICFG_LINK_ADDR;
            bits_next = icfg_pkg::ICFG_RST_BITS;
        end else if (stop_seen) begin
            link_next = icfg_pkg::ICFG_LINK_IDLE;
        end else begin
            case (link_reg)
                icfg_pkg::ICFG_LINK_IDLE: begin
                end
                icfg_pkg::ICFG_LINK_ADDR: begin
                    if (scl_rise) begin
                        shift_next = {shift_reg[6:0], sda_s2_reg};
                    end
                    if (scl_fall) begin
                        bits_next = bits_reg + 4'h1;
                        if (bits_reg == icfg_pkg::ICFG_LAST_ADDR_FALL) begin
                            link_next = icfg_pkg::ICFG_LINK_DATA;
                            // request at R/W bit clock fall
                            tx_evt = (shift_reg[7:1] == slave_addr) &
                                     shift_reg[0] & ~cfg_reg.txreq_off;
                            gc_evt = (shift_reg == 8'h00);
                        end
                    end
                end
                icfg_pkg::ICFG_LINK_DATA: begin
                end
                default: begin
                    link_next = icfg_pkg::ICFG_LINK_IDLE;
                end
            endcase
        end
        txpulse_next = tx_evt;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            link_reg <= icfg_pkg::ICFG_LINK_IDLE;
            shift_reg <= icfg_pkg::ICFG_RST_SHIFT;
            bits_reg <= icfg_pkg::ICFG_RST_BITS;
            txpulse_reg <= 1'b0;
        end else begin
            link_reg <= link_next;
            shift_reg <= shift_next;
            bits_reg <= bits_next;
            txpulse_reg <= txpulse_next;
        end
    end

    // Master clock divider and SCL drive
    // Leaving the master role parks the divider in the high phase, so a
    // restart never begins with a short low pulse
    logic [icfg_pkg::ICFG_DIV_W-1:0] div_reg, div_next;
    logic phase_hi_reg, phase_hi_next;
    logic oe_reg, oe_next;
    logic mclk_run;

    always_comb begin
        // clock only while enabled as master
        mclk_run = cfg_reg.mclk_en & master_active;
        div_next = div_reg;
        phase_hi_next = phase_hi_reg;
        if (!mclk_run) begin
            div_next = '0;
            phase_hi_next = 1'b1;
        end else if (div_reg == HALF_LAST) begin
            div_next = '0;
            phase_hi_next = ~phase_hi_reg;
        end else begin
            div_next = div_reg + 1'b1;
        end
        oe_next = cfg_reg.stretch | (mclk_run & ~phase_hi_reg);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            div_reg <= '0;
            phase_hi_reg <= 1'b1;
            oe_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            phase_hi_reg <= phase_hi_next;
            oe_reg <= oe_next;
        end
    end

    // Open drain: the level driven is always low, the enable does the work
    logic scl_out_reg, scl_out_next;

    always_comb begin
        scl_out_next = 1'b0;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            scl_out_reg <= 1'b0;
        end else begin
            scl_out_reg <= scl_out_next;
        end
    end

    assign scl_out = scl_out_reg;
    assign scl_oe = oe_reg;
    assign reg_rdata = rdata_reg;
    assign slave_tx_req = txpulse_reg;
    assign irq = irq_reg;

endmodule : icfg_config_bits

/* core/icfg_pkg.sv */
// Shared constants and carriers for the serial bus configuration bits.
// Assumes a 20 MHz core clock and 32-bit register words on a plain port.
package icfg_pkg;

    // Register byte offsets
    localparam logic [3:0] ICFG_OFS_CONFIG = 4'h0;
    localparam logic [3:0] ICFG_OFS_IRQ_STATUS = 4'h4;
    localparam logic [3:0] ICFG_OFS_IRQ_MASK = 4'h8;
    localparam logic [3:0] ICFG_OFS_GC_STATUS = 4'hC;

    // Field positions inside the configuration word
    localparam int ICFG_BIT_MCLK_EN = 7;
    localparam int ICFG_BIT_GC_CLEAR = 8;
    localparam int ICFG_BIT_TXREQ_OFF = 9;
    localparam int ICFG_BIT_STRETCH = 11;

    // Field positions inside status and mask words
    localparam int ICFG_IRQ_TXREQ = 0;
    localparam int ICFG_IRQ_GCALL = 1;
    localparam int ICFG_IRQ_W = 2;

    // Values after reset, and the fall count that ends the address byte
    localparam logic [ICFG_IRQ_W-1:0] ICFG_RST_IRQ = 2'h0;
    localparam logic [7:0] ICFG_RST_SHIFT = 8'h00;
    localparam logic [3:0] ICFG_RST_BITS = 4'h0;
    localparam logic [3:0] ICFG_LAST_ADDR_FALL = 4'h8;

    // Master serial clock timing
    localparam int ICFG_CORE_PERIOD_NS = 50;
    localparam int ICFG_MCLK_HALF_NS = 1250;
    localparam int ICFG_MCLK_HALF_CYC =
        (ICFG_MCLK_HALF_NS + ICFG_CORE_PERIOD_NS - 1) / ICFG_CORE_PERIOD_NS;
    localparam int ICFG_DIV_W = 8;

    typedef struct packed {
        logic stretch;
        logic txreq_off;
        logic gc_clear;
        logic mclk_en;
    } icfg_cfg_s;

    typedef enum logic [1:0] {
        ICFG_LINK_IDLE,
        ICFG_LINK_ADDR,
        ICFG_LINK_DATA
    } icfg_link_e;

endpackage : icfg_pkg

/* verification/icfg_config_bits_properties.sv */
// Checker on the configuration bits block ports.
// Assumes one clock domain; SCL and SDA are the resolved wire levels.
`timescale 1ns/1ps
module icfg_config_bits_properties #(
    parameter int ADDR_W = 4,
    parameter int MCLK_HALF = 2
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [6:0] slave_addr,
    input wire logic master_active,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic slave_tx_req,
    input wire logic irq
);
    localparam int MC_WIN = MCLK_HALF + 3;
    logic str_q, mck_q, off_q, scl_d, sda_d, fell8, cfg_wr, gcw, run;
    logic [3:0] rises, since;
    assign cfg_wr = reg_wr && reg_addr == icfg_pkg::ICFG_OFS_CONFIG;
    assign gcw = cfg_wr && reg_wdata[icfg_pkg::ICFG_BIT_GC_CLEAR];
    assign run = mck_q && master_active && !str_q;
    // Shadow bits and SCL edges since START, so no view inside is needed
    always_ff @(posedge core_clk) begin
        scl_d <= scl_in;
        sda_d <= sda_in;
        if (rst) begin
            {str_q, mck_q, off_q, fell8} <= 4'h0;
            rises <= 4'h0;
            since <= 4'hf;
        end else begin
            if (cfg_wr) begin
                str_q <= reg_wdata[icfg_pkg::ICFG_BIT_STRETCH];
                mck_q <= reg_wdata[icfg_pkg::ICFG_BIT_MCLK_EN];
                off_q <= reg_wdata[icfg_pkg::ICFG_BIT_TXREQ_OFF];
            end
            if (sda_d && !sda_in && scl_in) begin
                rises <= 4'h0;
                fell8 <= 1'b0;
            end else if (!scl_d && scl_in && rises != 4'hf)
                rises <= rises + 4'h1;
            if (scl_d && !scl_in) begin
                since <= 4'h0;
                fell8 <= fell8 || rises == 4'h8;
            end else if (since != 4'hf)
                since <= since + 4'h1;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    stretch_on_a: assert property (
        str_q && $past(str_q) && $past(str_q, 2) |-> scl_oe)
        else $error("SCL released while stretch set");
    stretch_off_a: assert property (
        !str_q && !$past(str_q) && !mck_q && !$past(mck_q) |-> !scl_oe)
        else $error("SCL pulled without cause");
    mclk_run_a: assert property (
        run |-> ##[0:MC_WIN] ($changed(scl_oe) || !run))
        else $error("master clock not toggling");
    txreq_off_a: assert property (
        off_q && $past(off_q) && $past(off_q, 3) |-> !slave_tx_req)
        else $error("request while disabled");
    txreq_rw_a: assert property (
        slave_tx_req |-> fell8 && since <= 4'h8)
        else $error("request not after R/W fall");
    txreq_pulse_a: assert property (slave_tx_req |=> !slave_tx_req)
        else $error("request longer than one cycle");
    gc_clear_a: assert property (reg_rd && !$past(gcw) &&
        !$past(gcw, 2) && reg_addr == icfg_pkg::ICFG_OFS_CONFIG
        |=> !reg_rdata[icfg_pkg::ICFG_BIT_GC_CLEAR])
        else $error("clear command did not return to zero");
    reserved_zero_a: assert property (
        reg_rd && reg_addr == icfg_pkg::ICFG_OFS_CONFIG
        |=> (reg_rdata & 32'hffff_f47f) == 32'h0000_0000)
        else $error("unused config bits read nonzero");
    scl_level_a: assert property (!scl_out)
        else $error("SCL drive level not low");
    cover property (slave_tx_req);
    cover property (run && $fell(scl_oe));
    cover property (str_q && scl_oe);
endmodule : icfg_config_bits_properties

/* verification/icfg_link_model.sv */
// Far-end bus master: START, one byte MSB first, ack clock, STOP.
// Open drain: drives lows only; both lines have pull-ups.
`timescale 1ns/1ps
module icfg_link_model (
    input wire logic scl,
    output logic scl_low = 1'b0,
    output logic sda_low = 1'b0
);
    // SCL stands high between frames; 400 ns per bit
    task automatic frame(input logic [7:0] b);
        #13 sda_low = 1'b1;
        #200;
        for (int i = 7; i >= -1; i--) begin
            scl_low = 1'b1;
            #100 sda_low = i >= 0 && !b[i[2:0]];
            #100 scl_low = 1'b0;
            // A stretching slave holds the clock low; wait it out
            wait (scl === 1'b1);
            #200;
        end
        scl_low = 1'b1;
        #100 sda_low = 1'b1;
        #100 scl_low = 1'b0;
        #200 sda_low = 1'b0;
        #200;
    endtask : frame
endmodule : icfg_link_model

/* verification/icfg_config_bits_bench.sv */
// Bench for the configuration bits block: register port tasks and a
// far-end master on the bus lines; the checker is bound in at the foot.
`timescale 1ns/1ps
module icfg_config_bits_bench;
    localparam int MCH = 2;
    localparam logic [3:0] CFG = icfg_pkg::ICFG_OFS_CONFIG;
    localparam logic [3:0] STA = icfg_pkg::ICFG_OFS_IRQ_STATUS;
    localparam logic [3:0] MSK = icfg_pkg::ICFG_OFS_IRQ_MASK;
    localparam logic [3:0] GCS = icfg_pkg::ICFG_OFS_GC_STATUS;
    localparam logic [31:0] ONE = 32'h0000_0001;
    localparam logic [31:0] ZERO = 32'h0000_0000;
    logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic master_active = 1'b0, oe_d = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = ZERO, reg_rdata;
    logic [6:0] slave_addr = 7'h2a;
    logic scl, sda, scl_out, scl_oe, slave_tx_req, irq, m_scl, m_sda;
    int n_fail = 0, n_tests = 0, n_req = 0, n_tog = 0, t0;
    assign scl = !(scl_oe || m_scl);
    assign sda = !m_sda;
    always #25 core_clk = !core_clk;
    always @(posedge core_clk) begin
        n_req <= n_req + int'(slave_tx_req === 1'b1);
        n_tog <= n_tog + int'(scl_oe !== oe_d);
        oe_d <= scl_oe;
    end
    icfg_config_bits #(.MCLK_HALF(MCH)) u_icfg_config_bits (
        .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .slave_addr(slave_addr),
        .master_active(master_active), .scl_in(scl), .sda_in(sda),
        .scl_out(scl_out), .scl_oe(scl_oe),
        .slave_tx_req(slave_tx_req), .irq(irq));
    icfg_link_model u_icfg_link_model (.scl(scl), .scl_low(m_scl),
        .sda_low(m_sda));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch at %0t: saw %h want %h", $time, s, e);
        end
    endtask : chk
    // One register cycle; a read compares the data in the next cycle
    task automatic acc(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        if (!w) begin
            @(negedge core_clk);
            chk(reg_rdata, d);
        end
    endtask : acc
    task automatic end_sim();
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_sim
    initial begin
        #200_000;
        n_fail++;
        end_sim();
    end
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        for (int a = 0; a < 16; a += 4)
            acc(1'b0, 4'(a), ZERO);
        acc(1'b0, 4'h2, ZERO);
        acc(1'b1, CFG, 32'hffff_f47f);
        acc(1'b0, CFG, ZERO);
        acc(1'b1, CFG, 32'h0000_0800);
        acc(1'b0, CFG, 32'h0000_0800);
        chk(32'(scl), ZERO);
        chk(32'(scl_out), ZERO);
        acc(1'b1, CFG, 32'h0000_0080);
        master_active <= 1'b1;
        t0 = n_tog;
        repeat (20) @(negedge core_clk);
        t0 = n_tog - t0;
        chk(32'(t0 >= (17 - MCH) / MCH && t0 <= 20 / MCH + 1), ONE);
        acc(1'b1, CFG, ZERO);
        repeat (3) @(negedge core_clk);
        chk(32'(scl_oe), ZERO);
        acc(1'b1, MSK, 32'h0000_0003);
        master_active <= 1'b0;
        t0 = n_req;
        u_icfg_link_model.frame({slave_addr, 1'b1});
        @(negedge core_clk);
        chk(32'(n_req - t0), ONE);
        chk(32'(irq), ONE);
        acc(1'b0, STA, ONE);
        // Software answers at once, well inside its budget
        acc(1'b1, STA, ONE);
        acc(1'b0, STA, ZERO);
        chk(32'(irq), ZERO);
        // A read aimed at another address must not raise a request
        u_icfg_link_model.frame({7'h15, 1'b1});
        @(negedge core_clk);
        chk(32'(n_req - t0), ONE);
        acc(1'b1, CFG, 32'h0000_0200);
        u_icfg_link_model.frame({slave_addr, 1'b1});
        @(negedge core_clk);
        chk(32'(n_req - t0), ONE);
        acc(1'b0, STA, ZERO);
        u_icfg_link_model.frame(8'h00);
        acc(1'b0, GCS, ONE);
        acc(1'b0, STA, 32'h0000_0002);
        chk(32'(irq), ONE);
        acc(1'b1, MSK, ZERO);
        acc(1'b0, MSK, ZERO);
        chk(32'(irq), ZERO);
        acc(1'b1, MSK, 32'h0000_0003);
        acc(1'b1, CFG, 32'h0000_0100);
        @(posedge core_clk);
        acc(1'b0, CFG, ZERO);
        acc(1'b0, GCS, ZERO);
        acc(1'b0, STA, ZERO);
        chk(32'(irq), ZERO);
        end_sim();
    end
endmodule : icfg_config_bits_bench
bind icfg_config_bits icfg_config_bits_properties #(.ADDR_W(ADDR_W),
    .MCLK_HALF(MCLK_HALF)) u_icfg_config_bits_properties (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .slave_addr(slave_addr),
    .master_active(master_active), .scl_in(scl_in), .sda_in(sda_in),
    .scl_out(scl_out), .scl_oe(scl_oe), .slave_tx_req(slave_tx_req),
    .irq(irq));
